// ==== standby_defines.svh ====
// Offsets, field positions, reset values and timing counts for the standby wake-up block.
// Included by the package, interval_counter, the control module and the bench; definitions only.
`ifndef STANDBY_DEFINES_SVH
`define STANDBY_DEFINES_SVH

`define OFS_WAIT_SEL      8'h00
`define OFS_CLK_CTRL      8'h04
`define OFS_CPU_STATUS    8'h08
`define OFS_IRQ_STATUS    8'h0C
`define OFS_IRQ_MASK      8'h10

`define WAIT_SEL_RST      4'h0
`define CLK_STOP_BIT      3
`define CLK_HALT_BIT      2
`define CTRL_IME_BIT      4

`define WSEL_2P20         3'h0
`define WSEL_2P17         3'h3
`define WSEL_2P15         3'h5
`define WSEL_2P13         3'h7

`define CNT_W             21
`define OSC_START_CYC     8'h40

`define IRQ_W             4
`define IRQ_BIT_STOP_END  0
`define IRQ_BIT_HALT_END  1
`define IRQ_BIT_VECTOR    2
`define IRQ_BIT_BADSEL    3

`endif

// ==== standby_pkg.sv ====
// Types shared by the standby wake-up block.
// Assumes standby_defines.svh is on the include path.
`include "standby_defines.svh"

package standby_pkg;

  typedef enum logic [2:0] {
    ST_RUN    = 3'b000,
    ST_HALT   = 3'b001,
    ST_OSCUP  = 3'b010,
    ST_WAIT   = 3'b011,
    ST_RESUME = 3'b100
  } pwr_state_e;

  typedef struct packed {
    logic [3:0] irq_req;
    logic [3:0] irq_en;
    logic [3:0] testable_only;
  } wake_src_s;

  typedef struct packed {
    logic       stop_cmd;
    logic       halt_cmd;
    logic       instr_done;
  } cpu_cmd_s;

  typedef struct packed {
    logic       cpu_run;
    logic       osc_enable;
    logic       take_vector;
    logic       do_reset_seq;
  } cpu_ctl_s;

  function automatic logic [4:0] wait_bit(input logic [2:0] sel);
    case (sel)
      `WSEL_2P20: wait_bit = 5'd20;
      `WSEL_2P17: wait_bit = 5'd17;
      `WSEL_2P15: wait_bit = 5'd15;
      default:    wait_bit = 5'd13;
    endcase
  endfunction

  function automatic logic sel_legal(input logic [2:0] sel);
    sel_legal = (sel == `WSEL_2P20) || (sel == `WSEL_2P17) || (sel == `WSEL_2P15) || (sel == `WSEL_2P13);
  endfunction

endpackage

// ==== pin_sync.sv ====
// Two-stage synchroniser for a bundle of asynchronous inputs.
// Assumes one clock; first stage read only by the second.
`timescale 1ns/10ps

module pin_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule

// ==== interval_counter.sv ====
// Clearable, gated interval counter timing oscillator stabilisation.
// Assumes it counts one step per oscillator cycle while enabled.
`timescale 1ns/10ps
`include "standby_defines.svh"

module interval_counter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic clear,
  input wire logic run,
  input wire logic [4:0] sel_bit,
  output logic ovf
);
  import standby_pkg::*;

  logic [`CNT_W-1:0] cnt_r;
  logic [`CNT_W-1:0] cnt_nxt;

  assign cnt_nxt = cnt_r + `CNT_W'(1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else if (ce) begin
      if (clear) begin
        cnt_r <= '0;
      end else if (run) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  // Pulse when the selected bit carries out of its lower bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf <= 1'b0;
    end else if (ce) begin
      ovf <= run && !clear && (cnt_nxt[sel_bit[4:0]] == 1'b1) && (cnt_nxt[sel_bit - 5'd1 -: 1] == 1'b0)
             && ((cnt_nxt & ((`CNT_W'(1) << sel_bit) - `CNT_W'(1))) == '0);
    end
  end
endmodule

// ==== standby_wakeup_control.sv ====
// Standby wake-up control: STOP/HALT entry, release and stabilisation wait.
// Assumes an AHB-Lite master, a CPU sequencer on clk and asynchronous irq pins.
`timescale 1ns/10ps
`include "standby_defines.svh"

// Function
// - Interrupt-released STOP holds CPU idle for selected stabilisation wait.
// - Select codes 000,011,101,111 give 2^20,2^17,2^15,2^13; others prohibited.
// - Wait count starts only after oscillator restart, for reset or interrupt.
// - Reset-release wait is build option 2^17 or 2^15 cycles.
// - Reset ending standby runs the ordinary reset sequence.
// - With master enable clear, resume in line; request flag stays set.
// - With master enable set, two instructions run, then vectored interrupt.
// - Testable-only sources never vector; resume in line.
// - Standby ends on an enabled interrupt request or external reset.
// - STOP sets clock control bit 3; HALT sets bit 2.
// - STOP stops oscillator; HALT gates only CPU clock.
module standby_wakeup_control #(
  parameter bit RESET_WAIT_2P17 = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire standby_pkg::wake_src_s wake_src,
  input wire standby_pkg::cpu_cmd_s cpu_cmd,
  output standby_pkg::cpu_ctl_s cpu_ctl,
  output logic irq
);
  import standby_pkg::*;

  pwr_state_e state_r;
  pwr_state_e state_nxt;
  logic [3:0] wait_sel_r;
  logic [3:0] clk_ctrl_r;
  logic ime_r;
  logic [`IRQ_W-1:0] irq_stat_r;
  logic [`IRQ_W-1:0] irq_mask_r;
  logic [`IRQ_W-1:0] irq_evt;
  logic [3:0] req_sync;
  logic [7:0] osc_cnt_r;
  logic from_reset_r;
  logic [1:0] instr_cnt_r;
  logic vec_pend_r;
  logic wait_ovf;
  logic wake;
  logic wake_vector;
  logic cnt_clear;
  logic [4:0] sel_bit;
  logic wr_pend_r;
  logic [7:0] addr_r;
  logic stop_take;
  logic halt_take;
  logic bus_take;
  logic [31:0] rdata_nxt;

  // Register write landing in its data phase
  function automatic logic reg_wr(input logic pend, input logic [7:0] a, input logic [7:0] ofs);
    reg_wr = pend && (a == ofs);
  endfunction

  // Request pins cross from outside the clock domain
  pin_sync #(.W(4)) u_req_sync (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(wake_src.irq_req),
    .q(req_sync)
  );

  assign wake = |(req_sync & wake_src.irq_en);
  // Testable-only sources wake the CPU but never raise a vector
  assign wake_vector = |(req_sync & wake_src.irq_en & ~wake_src.testable_only);

  // Standby instructions only count while the CPU is running
  assign stop_take = (state_r == ST_RUN) && cpu_cmd.stop_cmd;
  assign halt_take = (state_r == ST_RUN) && cpu_cmd.halt_cmd;

  // Reset-release wait uses build option; interrupt release uses register
  assign sel_bit = from_reset_r ? (RESET_WAIT_2P17 ? 5'd17 : 5'd15) : wait_bit(wait_sel_r[2:0]);
  assign cnt_clear = (state_r != ST_WAIT);

  // Held clear outside the wait, so oscillator start-up is never counted
  interval_counter u_icnt (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .clear(cnt_clear),
    .run(state_r == ST_WAIT),
    .sel_bit(sel_bit),
    .ovf(wait_ovf)
  );

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_RUN: begin
        if (cpu_cmd.stop_cmd) begin
          state_nxt = ST_HALT;
        end else if (cpu_cmd.halt_cmd) begin
          state_nxt = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake) begin
          state_nxt = clk_ctrl_r[`CLK_STOP_BIT] ? ST_OSCUP : ST_RESUME;
        end
      end
      ST_OSCUP: begin
        if (osc_cnt_r == `OSC_START_CYC) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (wait_ovf) begin
          state_nxt = ST_RESUME;
        end
      end
      ST_RESUME: begin
        state_nxt = ST_RUN;
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  // After reset the block runs as a STOP release: oscillator start, then wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_OSCUP;
    end else if (ce) begin
      state_r <= state_nxt;
    end
  end

  // Stands in for the oscillator start-up before the wait may begin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt_r <= 8'h00;
    end else if (ce) begin
      if (state_r == ST_OSCUP) begin
        osc_cnt_r <= osc_cnt_r + 8'h01;
      end else begin
        osc_cnt_r <= 8'h00;
      end
    end
  end

  // Reset release takes the build-option wait and the reset sequence
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      from_reset_r <= 1'b1;
    end else if (ce) begin
      if (state_r == ST_RESUME) begin
        from_reset_r <= 1'b0;
      end
    end
  end

  // Standby flags set by the instructions, cleared on leaving standby
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_ctrl_r <= 4'h0;
    end else if (ce) begin
      if (stop_take) begin
        clk_ctrl_r[`CLK_STOP_BIT] <= 1'b1;
      end else if (halt_take) begin
        clk_ctrl_r[`CLK_HALT_BIT] <= 1'b1;
      end else if (state_r == ST_RESUME) begin
        clk_ctrl_r[`CLK_STOP_BIT] <= 1'b0;
        clk_ctrl_r[`CLK_HALT_BIT] <= 1'b0;
      end else if (reg_wr(wr_pend_r, addr_r, `OFS_CLK_CTRL)) begin
        clk_ctrl_r[1:0] <= hwdata[1:0];
      end
    end
  end

  // Vectoring: two instructions after release, then the vector
  // Pending stays up for status readback until the third instruction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vec_pend_r <= 1'b0;
      instr_cnt_r <= 2'd0;
    end else if (ce) begin
      if (state_r == ST_RESUME && !from_reset_r) begin
        vec_pend_r <= ime_r && wake_vector;
        instr_cnt_r <= 2'd0;
      end else if (vec_pend_r && cpu_cmd.instr_done) begin
        if (instr_cnt_r == 2'd2) begin
          vec_pend_r <= 1'b0;
        end else begin
          instr_cnt_r <= instr_cnt_r + 2'd1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_ctl <= '{cpu_run: 1'b0, osc_enable: 1'b1, take_vector: 1'b0, do_reset_seq: 1'b0};
    end else if (ce) begin
      cpu_ctl.cpu_run <= (state_nxt == ST_RUN);
      // Oscillator drops one cycle after the CPU clock, once the stop flag is up
      cpu_ctl.osc_enable <= !(state_nxt == ST_HALT && clk_ctrl_r[`CLK_STOP_BIT]);
      cpu_ctl.take_vector <= vec_pend_r && cpu_cmd.instr_done && instr_cnt_r == 2'd1;
      cpu_ctl.do_reset_seq <= (state_r == ST_RESUME) && from_reset_r;
    end
  end

  // Interrupt status events
  assign irq_evt[`IRQ_BIT_STOP_END] = ce && state_r == ST_RESUME && clk_ctrl_r[`CLK_STOP_BIT];
  assign irq_evt[`IRQ_BIT_HALT_END] = ce && state_r == ST_RESUME && clk_ctrl_r[`CLK_HALT_BIT];
  assign irq_evt[`IRQ_BIT_VECTOR] = ce && cpu_ctl.take_vector;
  assign irq_evt[`IRQ_BIT_BADSEL] = ce && stop_take && !sel_legal(wait_sel_r[2:0]);

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_stat_r <= '0;
    end else if (ce) begin
      if (reg_wr(wr_pend_r, addr_r, `OFS_IRQ_STATUS)) begin
        irq_stat_r <= (irq_stat_r & ~hwdata[`IRQ_W-1:0]) | irq_evt;
      end else begin
        irq_stat_r <= irq_stat_r | irq_evt;
      end
    end
  end

  // Level output: high until software clears the status bit or masks it
  assign irq = |(irq_stat_r & irq_mask_r);

  // AHB-Lite slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase captured here; write data lands one cycle later
  assign bus_take = hready && hsel && htrans[1];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
    end else if (ce) begin
      if (hready) begin
        wr_pend_r <= bus_take && hwrite;
        addr_r <= haddr[7:0];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_sel_r <= `WAIT_SEL_RST;
      ime_r <= 1'b0;
      irq_mask_r <= '0;
    end else if (ce && wr_pend_r) begin
      if (reg_wr(wr_pend_r, addr_r, `OFS_WAIT_SEL)) begin
        wait_sel_r <= hwdata[3:0];
      end
      if (reg_wr(wr_pend_r, addr_r, `OFS_CLK_CTRL)) begin
        ime_r <= hwdata[`CTRL_IME_BIT];
      end
      if (reg_wr(wr_pend_r, addr_r, `OFS_IRQ_MASK)) begin
        irq_mask_r <= hwdata[`IRQ_W-1:0];
      end
    end
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    unique case (haddr[7:0])
      `OFS_WAIT_SEL: rdata_nxt = {28'h0, wait_sel_r};
      `OFS_CLK_CTRL: rdata_nxt = {27'h0, ime_r, clk_ctrl_r};
      `OFS_CPU_STATUS: rdata_nxt = {25'h0, vec_pend_r, from_reset_r, instr_cnt_r, state_r};
      `OFS_IRQ_STATUS: rdata_nxt = {28'h0, irq_stat_r};
      `OFS_IRQ_MASK: rdata_nxt = {28'h0, irq_mask_r};
      default: rdata_nxt = 32'h0000_0000;
    endcase
  end

  // Read data registered at the address phase, valid in the data phase
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
    end else if (ce) begin
      if (bus_take && !hwrite) begin
        hrdata <= rdata_nxt;
      end
    end
  end
endmodule

// ==== standby_wakeup_control_props.sv ====
// Concurrent checks on the standby wake-up block's ports.
// Assumes one clock domain; bound into every instance of the top module.
`timescale 1ns/10ps

module standby_wakeup_control_props
  import standby_pkg::*;
#(
  parameter bit RESET_WAIT_2P17 = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire standby_pkg::wake_src_s wake_src,
  input wire standby_pkg::cpu_cmd_s cpu_cmd,
  input wire standby_pkg::cpu_ctl_s cpu_ctl
);
  localparam int RST_WAIT = RESET_WAIT_2P17 ? 131072 : 32768;
  logic [20:0] cnt_r;
  logic stopped_r;
  logic from_rst_r;
  logic in_halt_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Cycles with the oscillator on since the CPU clock last stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      stopped_r <= 1'b0;
      from_rst_r <= 1'b1;
      in_halt_r <= 1'b0;
    end else if (cpu_ctl.cpu_run) begin
      cnt_r <= '0;
      stopped_r <= 1'b0;
      from_rst_r <= 1'b0;
      in_halt_r <= cpu_cmd.halt_cmd;
    end else begin
      cnt_r <= cnt_r + {20'h0, cpu_ctl.osc_enable};
      stopped_r <= stopped_r | !cpu_ctl.osc_enable;
    end
  end

  sequence stop_take;
    cpu_cmd.stop_cmd && cpu_ctl.cpu_run;
  endsequence
  sequence halt_take;
    cpu_cmd.halt_cmd && cpu_ctl.cpu_run;
  endsequence

  bus_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or not okay");
  stop_gate_a: assert property (stop_take |=> !cpu_ctl.cpu_run ##[0:1] !cpu_ctl.osc_enable)
    else $error("stop did not halt cpu and oscillator");
  halt_osc_a: assert property (halt_take |=> !cpu_ctl.cpu_run ##0 cpu_ctl.osc_enable [*8])
    else $error("halt stopped the oscillator");
  halt_wake_a: assert property (in_halt_r && $rose(|(wake_src.irq_req & wake_src.irq_en))
    |-> ##[1:8] cpu_ctl.cpu_run) else $error("enabled request did not end halt");
  stop_wait_a: assert property ($rose(cpu_ctl.cpu_run) && stopped_r && !from_rst_r
    |-> cnt_r >= 8192 && cnt_r <= 1048672) else $error("stop wait out of range");
  rst_wait_a: assert property ($rose(cpu_ctl.cpu_run) && from_rst_r
    |-> cnt_r >= RST_WAIT && cnt_r <= RST_WAIT + 96) else $error("reset wait out of range");
  rst_seq_a: assert property (cpu_ctl.do_reset_seq
    |-> cpu_ctl.cpu_run ##1 !cpu_ctl.do_reset_seq) else $error("reset sequence order");
  rst_only_a: assert property (cpu_ctl.do_reset_seq |-> from_rst_r) else $error("reset sequence without reset");
  vec_pulse_a: assert property (cpu_ctl.take_vector |=> !cpu_ctl.take_vector) else $error("vector held");
endmodule

bind standby_wakeup_control standby_wakeup_control_props #(.RESET_WAIT_2P17(RESET_WAIT_2P17)) u_props (
  .clk(clk),
  .rst_n(rst_n),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .wake_src(wake_src),
  .cpu_cmd(cpu_cmd),
  .cpu_ctl(cpu_ctl)
);

// ==== cpu_seq_model.sv ====
// Behavioural CPU sequencer: issues standby commands and retires instructions.
// Assumes issue is a one-cycle request from the bench, set up after configuration.
`timescale 1ns/10ps

module cpu_seq_model
  import standby_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] issue,
  input wire standby_pkg::cpu_ctl_s cpu_ctl,
  output standby_pkg::cpu_cmd_s cpu_cmd
);
  // Slow sequencer: one instruction every other cycle while clocked
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_cmd <= '0;
    end else begin
      cpu_cmd.stop_cmd <= issue[1] && cpu_ctl.cpu_run;
      cpu_cmd.halt_cmd <= issue[0] && cpu_ctl.cpu_run;
      cpu_cmd.instr_done <= cpu_ctl.cpu_run && !cpu_cmd.instr_done;
    end
  end
endmodule

// ==== tb_standby_wakeup_control.sv ====
// Self-checking bench for the standby wake-up block.
// Assumes the checker file is compiled alongside; one 40 MHz clock.
`timescale 1ns/10ps
`include "standby_defines.svh"

module tb_standby_wakeup_control;
  import standby_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic [1:0] issue = '0;
  wake_src_s wake_src = '0;
  cpu_cmd_s cpu_cmd;
  cpu_ctl_s cpu_ctl;
  logic [2:0] bad_tab [4] = '{3'h1, 3'h2, 3'h4, 3'h6};
  int vec_cnt = 0;
  int rst_cnt = 0;
  int seed = 20;
  int err_total = 0;
  int compares = 0;
  int n;
  int v0;
  logic [31:0] rd;

  always #12.5 clk = ~clk;
  // Counted mid-cycle so no check races the increment
  always @(negedge clk) begin
    vec_cnt += (cpu_ctl.take_vector === 1'b1);
    rst_cnt += (cpu_ctl.do_reset_seq === 1'b1);
  end

  standby_wakeup_control #(.RESET_WAIT_2P17(1'b0)) DUT (.clk(clk), .rst_n(rst_n), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .wake_src(wake_src), .cpu_cmd(cpu_cmd),
    .cpu_ctl(cpu_ctl), .irq(irq));
  cpu_seq_model u_cpu (.clk(clk), .rst_n(rst_n), .issue(issue), .cpu_ctl(cpu_ctl), .cpu_cmd(cpu_cmd));

  task automatic end_of_test();
    $display("mismatches %0d of %0d compares", err_total, compares);
    if (err_total == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wait_run(input logic lvl, input int lim);
    n = 0;
    while (cpu_ctl.cpu_run !== lvl) begin
      @(posedge clk);
      n++;
      if (n > lim) begin
        chk("wait timeout", 32'h0, 32'h1);
        end_of_test();
      end
    end
  endtask

  task automatic ready_wait();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (hreadyout !== 1'b1 && k < 20);
    if (hreadyout !== 1'b1) begin
      chk("bus timeout", 32'h0, 32'h1);
      end_of_test();
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    ready_wait();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    ready_wait();
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  task automatic irq_chk(input string nm, input logic e);
    @(posedge clk);
    chk(nm, {31'h0, e}, {31'h0, irq});
  endtask

  function automatic int exp_wait(input logic [2:0] s);
    case (s)
      `WSEL_2P20: return 1 << 20;
      `WSEL_2P17: return 1 << 17;
      `WSEL_2P15: return 1 << 15;
      default: return 1 << 13;
    endcase
  endfunction

  task automatic stop_run(input logic [2:0] sel, input int src, input logic master_irq_enable, input int exp_vec);
    int w;
    w = exp_wait(sel);
    wake_src.irq_en <= 4'h1 << src;
    bus(1'b1, `OFS_CLK_CTRL, {27'h0, master_irq_enable, 4'h0});
    repeat (4) @(posedge clk);
    bus(1'b1, `OFS_WAIT_SEL, {28'h0, 1'b1, sel});
    issue <= 2'b10;
    @(posedge clk);
    issue <= 2'b00;
    wait_run(1'b0, 10);
    repeat (2) @(posedge clk);
    chk("osc_enable", 32'h0, {31'h0, cpu_ctl.osc_enable});
    bus(1'b0, `OFS_CLK_CTRL, 32'h0);
    chk("stop_flag", 32'h8, rd & 32'h8);
    v0 = vec_cnt;
    wake_src.irq_req <= 4'h1 << src;
    wait_run(1'b1, w + 200);
    wake_src.irq_req <= 4'h0;
    chk("stop_wait", 32'h1, {31'h0, n >= w + 40 && n <= w + 96});
    repeat (12) @(posedge clk);
    chk("vector", exp_vec, vec_cnt - v0);
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    wait_run(1'b1, 40000);
    chk("reset_wait", 32'h1, {31'h0, n >= 32768 && n <= 32868});
    chk("reset_seq", 32'h1, rst_cnt);
    bus(1'b0, `OFS_WAIT_SEL, 32'h0);
    chk("wait_sel_rst", {28'h0, `WAIT_SEL_RST}, rd);
    v0 = $random(seed);
    bus(1'b1, `OFS_WAIT_SEL, v0);
    bus(1'b0, `OFS_WAIT_SEL, 32'h0);
    chk("wait_sel_rw", v0 & 32'hF, rd);
    bus(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Halt: a disabled request must not wake, an enabled one must
    wake_src.irq_en <= 4'h1;
    bus(1'b1, `OFS_IRQ_MASK, 32'hF);
    issue <= 2'b01;
    @(posedge clk);
    issue <= 2'b00;
    wait_run(1'b0, 10);
    bus(1'b0, `OFS_CLK_CTRL, 32'h0);
    chk("halt_flag", 32'h4, rd & 32'h4);
    chk("halt_osc", 32'h1, {31'h0, cpu_ctl.osc_enable});
    bus(1'b0, `OFS_CPU_STATUS, 32'h0);
    chk("halt_state", {29'h0, ST_HALT}, rd);
    wake_src.irq_req <= 4'h4;
    repeat (10) @(posedge clk);
    chk("halt_hold", 32'h0, {31'h0, cpu_ctl.cpu_run});
    v0 = vec_cnt;
    wake_src.irq_req <= 4'h5;
    wait_run(1'b1, 12);
    wake_src.irq_req <= 4'h0;
    repeat (8) @(posedge clk);
    chk("halt_vec", 32'h0, vec_cnt - v0);
    bus(1'b1, `OFS_IRQ_MASK, 32'h0);
    irq_chk("irq_masked", 1'b0);
    bus(1'b1, `OFS_IRQ_MASK, 32'hF);
    irq_chk("irq_set", 1'b1);
    bus(1'b1, `OFS_IRQ_STATUS, 32'hF);
    irq_chk("irq_clr", 1'b0);
    stop_run(`WSEL_2P13, 0, 1'b1, 1);
    wake_src.testable_only <= 4'h2;
    stop_run(bad_tab[{$random(seed)} % 4], 1, 1'b1, 0);
    bus(1'b0, `OFS_IRQ_STATUS, 32'h0);
    chk("bad_sel", 32'h8, rd & 32'h8);
    wake_src.testable_only <= 4'h0;
    stop_run(`WSEL_2P15, 0, 1'b0, 0);
    end_of_test();
  end
endmodule
